// ==== design/sps_device.sv ====
// Sensor end: power-down and wake sequencing, serial port slave, quadrature outputs.
// Assumes link_clk is the 18 MHz resonator; rst comes from another domain and is synced.
// Behaviour
// - Host waits 100 us between two writes.
// - Host waits 100 us after write before read.
// - Host waits 120 ns after read before write.
// - Host waits 120 ns between two reads.
// - Registers hold fresh image data 3.2 ms after wake.
// - Host allows 75 more frames for exposure settling.
// - Host holds sleep pin 700 us to power down.
// - 100 us sleep pulse resets port; normal recovery follows.
// - Frames captured at nominal 1500 per second.
// - Power-down entered about 700 us after pin rise.
// - Quadrature valid 705 us plus 75 frames after wake.
// - Quadrature valid 705 us plus 40 frames after power-up.
// - Unfinished transaction reset by watchdog after 0.8 s.
// - Quadrature state frozen while sleep pin high.
// - Only the host starts serial transfers.
// - Sleep pin high requests power-down, low runs.
`timescale 1ns/1ps
module sps_device #(
    parameter int FRAME_CYC = sps_pkg::FRAME_CYC,
    parameter int SLEEP_CYC = sps_pkg::SLEEP_CYC,
    parameter int WAKE_CYC = sps_pkg::WAKE_CYC,
    parameter int COMPUTE_CYC = sps_pkg::COMPUTE_CYC,
    parameter int SPTT_CYC = sps_pkg::SPTT_CYC
) (
    input wire logic link_clk,
    input wire logic rst,
    sps_link_if.device link,
    input wire logic [1:0] motion_step,
    input wire logic [1:0] motion_dir,
    output logic powered_down,
    output logic quad_valid,
    output logic data_valid,
    output sps_pkg::sps_byte_t config_value
);
    import sps_pkg::*;

    logic [3:0] sync_q;
    logic sclk_d;
    logic [CNT_W-1:0] pin_cnt;
    logic [CNT_W-1:0] fcnt;
    logic [CNT_W-1:0] tcnt;
    logic [CNT_W-1:0] ccnt;
    logic [CNT_W-1:0] wcnt;
    logic [6:0] frames;
    logic [6:0] frame_goal;
    sps_dev_state_t state;
    sps_dev_state_t next_state;
    logic [3:0] bit_cnt;
    sps_byte_t cmd_sh;
    sps_byte_t wr_sh;
    sps_byte_t rd_sh;
    sps_byte_t rd_value;
    sps_byte_t status_byte;
    logic is_rd;
    logic [1:0] rd_clr;
    logic [1:0] quad [2];
    sps_byte_t delta [2];

    // Pins and reset cross into the resonator domain
    sps_sync #(.W(4)) u_sync (
        .clk(link_clk),
        .d({rst, link.sleep_request_pin, link.serial_clk, link.sdio}),
        .q(sync_q)
    );

    wire rst_s = sync_q[3];
    wire pin_s = sync_q[2];
    wire sclk_s = sync_q[1];
    wire sdio_s = sync_q[0];

    // Serial clock edges, seen only as the host makes them
    wire rise = sclk_s & ~sclk_d;
    wire fall = ~sclk_s & sclk_d;

    // Interval events, all counted on the resonator
    wire frame_tick = fcnt == CNT_W'(FRAME_CYC - 1);
    wire sleep_reached = pin_s && pin_cnt == CNT_W'(SLEEP_CYC - 1);
    wire pdr_hit = pin_s && pin_cnt == CNT_W'(PDR_CYC - 1);
    wire wake_done = tcnt == CNT_W'(WAKE_CYC - 1);
    wire settle_done = frame_tick && frames == frame_goal - 7'h01;
    wire wdog_hit = wcnt == CNT_W'(SPTT_CYC - 1);
    wire ser_clr = rst_s | pdr_hit | wdog_hit;
    wire busy = (bit_cnt != 4'h0) | link.sdio_dev_oe;

    // Serial decode
    wire [7:0] byte_in = {cmd_sh[6:0], sdio_s};
    wire addr_done = rise && bit_cnt == ADDR_LAST;
    wire xfer_done = rise && bit_cnt == LAST_BIT;
    wire wr_commit = xfer_done && !is_rd && cmd_sh[6:0] == REG_CFG;
    wire rd_start = addr_done && !byte_in[7];

    // Read data selection by address
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_DATA_BIT] = data_valid;
        status_byte[ST_QUAD_BIT] = quad_valid;
        case (byte_in[6:0])
            REG_ID: rd_value = ID_VALUE;
            REG_STATUS: rd_value = status_byte;
            REG_DX: rd_value = delta[0];
            REG_DY: rd_value = delta[1];
            REG_CFG: rd_value = config_value;
            default: rd_value = 8'h00;
        endcase
    end

    // Reads of a motion count clear it
    assign rd_clr[0] = rd_start && byte_in[6:0] == REG_DX;
    assign rd_clr[1] = rd_start && byte_in[6:0] == REG_DY;

    // Power sequence next state
    always_comb begin
        next_state = state;
        case (state)
            D_WAKE: if (wake_done) begin
                next_state = D_SETTLE;
            end
            D_SETTLE: if (settle_done) begin
                next_state = D_RUN;
            end
            D_RUN: next_state = D_RUN;
            D_PEND: if (sleep_reached) begin
                next_state = D_SLEEP;
            end
            D_SLEEP: next_state = D_SLEEP;
            default: next_state = D_WAKE;
        endcase
        if (pin_s && state != D_PEND && state != D_SLEEP) begin
            next_state = D_PEND;
        end else if (!pin_s && (state == D_PEND || state == D_SLEEP)) begin
            next_state = D_WAKE;
        end
    end

    // Power sequence registers
    always_ff @(posedge link_clk) begin
        if (rst_s) begin
            state <= D_WAKE;
            frame_goal <= FRAMES_AFTER_PU;
            powered_down <= 1'b0;
            quad_valid <= 1'b0;
        end else begin
            state <= next_state;
            powered_down <= next_state == D_SLEEP;
            quad_valid <= next_state == D_RUN;
            if (pin_s) begin
                frame_goal <= FRAMES_AFTER_PD;
            end
        end
    end

    // State timer and frame tally restart on every state change
    always_ff @(posedge link_clk) begin
        if (rst_s || next_state != state) begin
            tcnt <= '0;
            frames <= 7'h00;
        end else begin
            tcnt <= tcnt + CNT_W'(1);
            if (frame_tick) begin
                frames <= frames + 7'h01;
            end
        end
    end

    // Free running frame clock and sleep pin high time
    always_ff @(posedge link_clk) begin
        if (rst_s || frame_tick) begin
            fcnt <= '0;
        end else begin
            fcnt <= fcnt + CNT_W'(1);
        end
        if (rst_s || !pin_s) begin
            pin_cnt <= '0;
        end else if (pin_cnt != {CNT_W{1'b1}}) begin
            pin_cnt <= pin_cnt + CNT_W'(1);
        end
    end

    // Data from the first image is ready after the compute time
    always_ff @(posedge link_clk) begin
        if (rst_s || pin_s) begin
            ccnt <= '0;
            data_valid <= 1'b0;
        end else if (!data_valid) begin
            ccnt <= ccnt + CNT_W'(1);
            data_valid <= ccnt == CNT_W'(COMPUTE_CYC - 1);
        end
    end

    // Serial port slave; cleared by reset, short sleep pulse or watchdog
    always_ff @(posedge link_clk) begin
        sclk_d <= sclk_s;
        if (ser_clr) begin
            bit_cnt <= 4'h0;
            is_rd <= 1'b0;
            wcnt <= '0;
            link.sdio_dev_oe <= 1'b0;
            link.sdio_dev_out <= 1'b0;
        end else begin
            wcnt <= busy ? wcnt + CNT_W'(1) : '0;
            if (rise) begin
                bit_cnt <= bit_cnt + 4'h1;
                wr_sh <= {wr_sh[6:0], sdio_s};
                if (!bit_cnt[3]) begin
                    cmd_sh <= byte_in;
                end
                if (addr_done) begin
                    is_rd <= !byte_in[7];
                    rd_sh <= rd_value;
                end
                if (xfer_done) begin
                    link.sdio_dev_oe <= 1'b0;
                end
            end
            // Read data changes on the falling serial clock
            if (fall && is_rd && bit_cnt[3]) begin
                link.sdio_dev_oe <= 1'b1;
                link.sdio_dev_out <= rd_sh[7];
                rd_sh <= {rd_sh[6:0], 1'b0};
            end
        end
    end

    // Writable configuration byte
    always_ff @(posedge link_clk) begin
        if (rst_s) begin
            config_value <= CFG_RST;
        end else if (wr_commit && !ser_clr) begin
            config_value <= {wr_sh[6:0], sdio_s};
        end
    end

    // Per axis quadrature state and motion count
    for (genvar i = 0; i < 2; i++) begin : g_axis
        wire sign_step = motion_step[i] && data_valid;
        always_ff @(posedge link_clk) begin
            if (rst_s) begin
                quad[i] <= 2'h0;
                delta[i] <= 8'h00;
            end else begin
                if (motion_step[i] && !pin_s) begin
                    quad[i] <= motion_dir[i] ? {quad[i][0], ~quad[i][1]} :
                        {~quad[i][0], quad[i][1]};
                end
                // A step in the clearing cycle is kept
                delta[i] <= (rd_clr[i] ? 8'h00 : delta[i]) +
                    (sign_step ? (motion_dir[i] ? 8'h01 : 8'hFF) : 8'h00);
            end
        end
    end

    // Quadrature pins straight from the state flops
    assign link.horiz_quad_phase_a = quad[0][1];
    assign link.horiz_quad_phase_b = quad[0][0];
    assign link.vert_quad_phase_a = quad[1][1];
    assign link.vert_quad_phase_b = quad[1][0];

endmodule

// ==== design/sps_host.sv ====
// Host end: serial port master with command spacing, and sleep pin pulse control.
// Assumes sys_clk at 25 MHz and user commands on the same clock.
`timescale 1ns/1ps
module sps_host #(
    parameter int PDW_CYC = sps_pkg::H_PDW_CYC,
    parameter int SETTLE_CYC = sps_pkg::H_SETTLE_CYC,
    parameter int COMPUTE_CYC = sps_pkg::H_COMPUTE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    sps_link_if.host link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire sps_pkg::sps_addr_t cmd_addr,
    input wire sps_pkg::sps_byte_t cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output sps_pkg::sps_byte_t rsp_rdata,
    input wire logic sleep_req,
    input wire logic port_reset_req,
    output logic [3:0] quad_phases,
    output logic motion_trusted
);
    import sps_pkg::*;

    logic [4:0] sync_q;
    logic [CNT_W-1:0] pcnt;
    logic [CNT_W-1:0] wk;
    logic [11:0] tmr;
    logic [3:0] bit_cnt;
    logic [15:0] shreg;
    sps_byte_t rx;
    logic rd;
    sps_host_state_t state;

    // Pins from the sensor cross into the system domain
    sps_sync #(.W(5)) u_sync (
        .clk(sys_clk),
        .d({link.horiz_quad_phase_a, link.horiz_quad_phase_b, link.vert_quad_phase_a,
            link.vert_quad_phase_b, link.sdio}),
        .q(sync_q)
    );
    assign quad_phases = sync_q[4:1];

    wire sdio_s = sync_q[0];
    wire tmr_zero = tmr == 12'h000;
    wire regs_ok = wk >= CNT_W'(COMPUTE_CYC - 1);
    assign cmd_ready = state == H_IDLE && !link.sleep_request_pin && regs_ok;

    // Sleep pin: long hold for power-down, short pulse for port reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link.sleep_request_pin <= 1'b0;
            pcnt <= '0;
        end else if (!link.sleep_request_pin) begin
            if (sleep_req) begin
                link.sleep_request_pin <= 1'b1;
                pcnt <= CNT_W'(PDW_CYC - 1);
            end else if (port_reset_req) begin
                link.sleep_request_pin <= 1'b1;
                pcnt <= CNT_W'(H_PDR_CYC - 1);
            end
        end else if (pcnt != '0) begin
            pcnt <= pcnt - CNT_W'(1);
        end else if (!sleep_req) begin
            link.sleep_request_pin <= 1'b0;
        end
    end

    // Time since wake decides when registers and motion can be trusted
    always_ff @(posedge sys_clk) begin
        if (rst || link.sleep_request_pin) begin
            wk <= '0;
            motion_trusted <= 1'b0;
        end else begin
            if (wk != CNT_W'(SETTLE_CYC - 1)) begin
                wk <= wk + CNT_W'(1);
            end
            motion_trusted <= wk == CNT_W'(SETTLE_CYC - 1);
        end
    end

    // Serial master: clock idles high, data set while low, sampled at rise
    always_ff @(posedge sys_clk) begin
        rsp_valid <= 1'b0;
        if (rst) begin
            state <= H_IDLE;
            tmr <= 12'h000;
            bit_cnt <= 4'h0;
            rd <= 1'b0;
            link.serial_clk <= 1'b1;
            link.sdio_host_oe <= 1'b0;
            link.sdio_host_out <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            if (!tmr_zero) begin
                tmr <= tmr - 12'h001;
            end
            case (state)
                H_IDLE: if (cmd_valid && cmd_ready) begin
                    shreg <= {cmd_write, cmd_addr, cmd_wdata};
                    rd <= !cmd_write;
                    bit_cnt <= 4'h0;
                    link.serial_clk <= 1'b0;
                    link.sdio_host_out <= cmd_write;
                    link.sdio_host_oe <= 1'b1;
                    tmr <= 12'(SCLK_HALF - 1);
                    state <= H_LOW;
                end
                H_LOW: if (tmr_zero) begin
                    link.serial_clk <= 1'b1;
                    tmr <= 12'(SCLK_HALF - 1);
                    state <= H_HIGH;
                    if (rd && bit_cnt[3]) begin
                        rx <= {rx[6:0], sdio_s};
                    end
                end
                H_HIGH: if (tmr_zero) begin
                    if (bit_cnt == LAST_BIT) begin
                        link.sdio_host_oe <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= rd ? rx : 8'h00;
                        tmr <= rd ? 12'(H_RD_GAP - 1) : 12'(H_WR_GAP - 1);
                        state <= H_GAP;
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                        shreg <= {shreg[14:0], 1'b0};
                        link.sdio_host_out <= shreg[14];
                        if (rd && bit_cnt == ADDR_LAST) begin
                            link.sdio_host_oe <= 1'b0;
                            tmr <= 12'(H_HOLD_CYC - 1);
                            state <= H_HOLD;
                        end else begin
                            link.serial_clk <= 1'b0;
                            tmr <= 12'(SCLK_HALF - 1);
                            state <= H_LOW;
                        end
                    end
                end
                H_HOLD: if (tmr_zero) begin
                    link.serial_clk <= 1'b0;
                    tmr <= 12'(SCLK_HALF - 1);
                    state <= H_LOW;
                end
                H_GAP: if (tmr_zero) begin
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule

// ==== design/sps_link_if.sv ====
// Pins between host and sensor: sleep request, serial clock, shared data, quadrature.
// Assumes the data line has a pull-up when neither end drives it.
`timescale 1ns/1ps
interface sps_link_if;
    logic sleep_request_pin;
    logic serial_clk;
    logic sdio_host_out;
    logic sdio_host_oe;
    logic sdio_dev_out;
    logic sdio_dev_oe;
    logic sdio;
    logic horiz_quad_phase_a;
    logic horiz_quad_phase_b;
    logic vert_quad_phase_a;
    logic vert_quad_phase_b;

    // Wire level from the two enables, pulled high when idle
    assign sdio = sdio_host_oe ? sdio_host_out : (sdio_dev_oe ? sdio_dev_out : 1'b1);

    modport device (
        input sleep_request_pin, serial_clk, sdio,
        output sdio_dev_out, sdio_dev_oe,
        output horiz_quad_phase_a, horiz_quad_phase_b, vert_quad_phase_a, vert_quad_phase_b
    );
    modport host (
        output sleep_request_pin, serial_clk, sdio_host_out, sdio_host_oe,
        input sdio, horiz_quad_phase_a, horiz_quad_phase_b, vert_quad_phase_a, vert_quad_phase_b
    );
endinterface

// ==== design/sps_pkg.sv ====
// Shared constants and types for the sensor power and serial port timing pair.
// Assumes the device end runs from an 18 MHz resonator and the host from 25 MHz.
package sps_pkg;

    typedef logic [7:0] sps_byte_t;
    typedef logic [6:0] sps_addr_t;

    // Clock rates, frame rate and counter width
    localparam int LINK_KHZ = 18000;
    localparam int SYS_MHZ = 25;
    localparam int FRAME_RATE = 1500;
    localparam int CNT_W = 24;

    // Device side times and their resonator cycle counts
    localparam int T_SLEEP_US = 700;
    localparam int T_PDR_US = 100;
    localparam int T_WAKE_US = 705;
    localparam int T_COMPUTE_US = 3200;
    localparam int T_SPTT_MS = 800;
    localparam int FRAME_CYC = LINK_KHZ * 1000 / FRAME_RATE;
    localparam int SLEEP_CYC = T_SLEEP_US * LINK_KHZ / 1000;
    localparam int PDR_CYC = (T_PDR_US * LINK_KHZ + 999) / 1000;
    localparam int WAKE_CYC = (T_WAKE_US * LINK_KHZ + 999) / 1000;
    localparam int COMPUTE_CYC = T_COMPUTE_US * LINK_KHZ / 1000;
    localparam int SPTT_CYC = T_SPTT_MS * LINK_KHZ;
    localparam logic [6:0] FRAMES_AFTER_PD = 7'h4B;
    localparam logic [6:0] FRAMES_AFTER_PU = 7'h28;

    // Host side times and their system cycle counts
    localparam int T_SWW_US = 100;
    localparam int T_SWR_US = 100;
    localparam int T_SRW_NS = 120;
    localparam int T_SRR_NS = 120;
    localparam int T_HOLD_US = 100;
    localparam int T_PDW_US = 700;
    localparam int T_PUPD_MS = 50;
    localparam int H_SWW_CYC = T_SWW_US * SYS_MHZ;
    localparam int H_SWR_CYC = T_SWR_US * SYS_MHZ;
    localparam int H_SRW_CYC = (T_SRW_NS * SYS_MHZ + 999) / 1000;
    localparam int H_SRR_CYC = (T_SRR_NS * SYS_MHZ + 999) / 1000;
    localparam int H_WR_GAP = (H_SWW_CYC > H_SWR_CYC) ? H_SWW_CYC : H_SWR_CYC;
    localparam int H_RD_GAP = (H_SRW_CYC > H_SRR_CYC) ? H_SRW_CYC : H_SRR_CYC;
    localparam int H_HOLD_CYC = T_HOLD_US * SYS_MHZ;
    localparam int H_PDW_CYC = T_PDW_US * SYS_MHZ;
    localparam int H_PDR_CYC = T_PDR_US * SYS_MHZ;
    localparam int H_SETTLE_CYC = T_PUPD_MS * SYS_MHZ * 1000;
    localparam int H_COMPUTE_CYC = T_COMPUTE_US * SYS_MHZ;
    localparam int SCLK_HALF = 12;

    // Serial frame: one direction bit, seven address bits, eight data bits
    localparam logic [3:0] ADDR_LAST = 4'h7;
    localparam logic [3:0] LAST_BIT = 4'hF;

    // Register map
    localparam sps_addr_t REG_ID = 7'h00;
    localparam sps_addr_t REG_STATUS = 7'h01;
    localparam sps_addr_t REG_DX = 7'h02;
    localparam sps_addr_t REG_DY = 7'h03;
    localparam sps_addr_t REG_CFG = 7'h04;
    localparam sps_byte_t CFG_RST = 8'h00;
    localparam sps_byte_t ID_VALUE = 8'h5A; // Arbitrary value
    localparam int ST_DATA_BIT = 0;
    localparam int ST_QUAD_BIT = 1;

    typedef enum logic [2:0] {
        D_WAKE = 3'b000,
        D_SETTLE = 3'b001,
        D_RUN = 3'b010,
        D_PEND = 3'b011,
        D_SLEEP = 3'b100
    } sps_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW = 3'b001,
        H_HIGH = 3'b010,
        H_HOLD = 3'b011,
        H_GAP = 3'b100
    } sps_host_state_t;

endpackage

// ==== design/sps_sync.sv ====
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; no relation between bits is kept.
`timescale 1ns/1ps
module sps_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        stage1 <= d;
        q <= stage1;
    end
endmodule

// ==== sim/sps_asserts.sv ====
// Checker: timing of the pins between host end and sensor end.
// Assumes bench clocks and reset; counts follow the shortened parameters.
`timescale 1ns/1ps
module sps_asserts #(
    parameter int PDW_CYC = sps_pkg::H_PDW_CYC,
    parameter int PDR_CYC = sps_pkg::H_PDR_CYC,
    parameter int SLEEP_CYC = sps_pkg::SLEEP_CYC,
    parameter int WAKE_CYC = 30,
    parameter int FRAME_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic link_clk,
    input wire logic rst,
    input wire logic sleep_request_pin,
    input wire logic serial_clk,
    input wire logic sdio_host_oe,
    input wire logic sdio_dev_oe,
    input wire logic horiz_quad_phase_a,
    input wire logic horiz_quad_phase_b,
    input wire logic vert_quad_phase_a,
    input wire logic vert_quad_phase_b,
    input wire logic powered_down,
    input wire logic quad_valid
);
    logic [23:0] clk_hi;
    logic [23:0] pin_hi;
    logic [23:0] l_hi;
    logic [23:0] l_lo;
    logic armed;
    wire [3:0] quad = {horiz_quad_phase_a, horiz_quad_phase_b, vert_quad_phase_a, vert_quad_phase_b};
    // High runs on the host clock; armed once the host lets go of the data line
    always_ff @(posedge sys_clk) begin
        clk_hi <= (rst || !serial_clk) ? 24'h0 : clk_hi + 24'h1;
        pin_hi <= (rst || !sleep_request_pin) ? 24'h0 : pin_hi + 24'h1;
        armed <= !rst && ($fell(sdio_host_oe) || (armed && serial_clk));
    end
    // Sleep pin level counted in link cycles
    always_ff @(posedge link_clk) begin
        l_hi <= (rst || !sleep_request_pin) ? 24'h0 : l_hi + 24'h1;
        l_lo <= (rst || sleep_request_pin) ? 24'h0 : l_lo + 24'h1;
    end
    a_no_drive_clash: assert property (@(posedge sys_clk) disable iff (rst)
        !(sdio_host_oe && sdio_dev_oe)) else $error("Both ends drive the data line");
    a_write_gap: assert property (@(posedge sys_clk) disable iff (rst)
        (armed && $fell(serial_clk)) |-> clk_hi >= 24'h9C4) else $error("Frame too soon");
    a_pin_width: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(sleep_request_pin) |-> pin_hi >= PDR_CYC) else $error("Sleep pulse too short");
    a_sleep_hold: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(sleep_request_pin) && pin_hi > PDR_CYC) |-> pin_hi >= PDW_CYC)
        else $error("Power-down hold too short");
    a_quad_frozen: assert property (@(posedge link_clk) disable iff (rst)
        (l_hi > 24'h6) |-> $stable(quad)) else $error("Quadrature moved while asleep");
    a_sleep_entry: assert property (@(posedge link_clk) disable iff (rst)
        (l_hi == SLEEP_CYC + 8) |-> powered_down) else $error("Power-down not entered");
    a_wake_release: assert property (@(posedge link_clk) disable iff (rst)
        (l_lo == 24'h8) |-> !powered_down) else $error("Still powered down");
    a_quad_in_time: assert property (@(posedge link_clk) disable iff (rst)
        (l_lo == WAKE_CYC + 76 * FRAME_CYC + 8) |-> quad_valid) else $error("Quadrature late");
    a_quad_not_early: assert property (@(posedge link_clk) disable iff (rst)
        (l_lo == WAKE_CYC) |-> !quad_valid) else $error("Quadrature valid too early");
    c_write_gap: cover property (@(posedge sys_clk) disable iff (rst) armed && $fell(serial_clk));
    c_sleep: cover property (@(posedge link_clk) disable iff (rst) $rose(powered_down));
    c_wake: cover property (@(posedge link_clk) disable iff (rst) $rose(quad_valid));
endmodule

// ==== sim/testbench.sv ====
// Testbench: host and sensor ends joined by the link, driven through user commands.
// Assumes the shortened counts set below; link clock made here at 32 ns.
`timescale 1ns/1ps
module testbench;
    import sps_pkg::*;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    sps_addr_t cmd_addr = 7'h00;
    sps_byte_t cmd_wdata = 8'h00;
    logic sleep_req = 1'b0;
    logic port_reset_req = 1'b0;
    logic [1:0] motion_step = 2'h0;
    logic [1:0] motion_dir = 2'h0;
    logic cmd_ready, rsp_valid, powered_down, quad_valid, data_valid, motion_trusted;
    sps_byte_t rsp_rdata;
    sps_byte_t config_value;
    logic [3:0] quad_phases;
    logic [3:0] held;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    sps_link_if link ();
    sps_device #(.FRAME_CYC(40), .WAKE_CYC(30), .COMPUTE_CYC(50))
    i_sps_device (.link_clk(link_clk), .rst(rst), .link(link.device), .motion_step(motion_step),
        .motion_dir(motion_dir), .powered_down(powered_down), .quad_valid(quad_valid),
        .data_valid(data_valid), .config_value(config_value));
    sps_host #(.SETTLE_CYC(500), .COMPUTE_CYC(100)) i_sps_host (.sys_clk(sys_clk),
        .rst(rst), .link(link.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .port_reset_req(port_reset_req),
        .quad_phases(quad_phases), .motion_trusted(motion_trusted));
    sps_asserts i_sps_asserts (
        .sys_clk(sys_clk), .link_clk(link_clk), .rst(rst),
        .sleep_request_pin(link.sleep_request_pin), .serial_clk(link.serial_clk),
        .sdio_host_oe(link.sdio_host_oe), .sdio_dev_oe(link.sdio_dev_oe),
        .horiz_quad_phase_a(link.horiz_quad_phase_a), .horiz_quad_phase_b(link.horiz_quad_phase_b),
        .vert_quad_phase_a(link.vert_quad_phase_a), .vert_quad_phase_b(link.vert_quad_phase_b),
        .powered_down(powered_down), .quad_valid(quad_valid));
    // Host clock and an unrelated link clock
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            conclude();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One command: held until taken, then the response data is compared
    task automatic access(input logic wr, input sps_addr_t a, input sps_byte_t d, input sps_byte_t e);
        int n;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        for (n = 0; n < 20000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 5000 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
        check(rsp_valid, 1'b1);
        check(rsp_rdata, e);
    endtask
    // One motion step pulse in the link domain
    task automatic step(input logic [1:0] s, input logic [1:0] d);
        @(negedge link_clk);
        motion_dir = d;
        motion_step = s;
        @(negedge link_clk);
        motion_step = 2'h0;
        idle(100);
    endtask
    initial begin
        idle(20);
        rst = 1'b0;
        idle(100);
        check(data_valid, 1'b1);
        check(quad_valid, 1'b0);
        idle(1400);
        check(quad_valid, 1'b1);
        $display("Test power_up done");
        access(1'b1, REG_CFG, 8'hA5, 8'h00);
        check(config_value, 8'hA5);
        access(1'b0, REG_CFG, 8'h00, 8'hA5);
        access(1'b0, REG_ID, 8'h00, ID_VALUE);
        access(1'b0, REG_STATUS, 8'h00, 8'h03);
        access(1'b1, REG_CFG, 8'h3C, 8'h00);
        access(1'b1, REG_CFG, 8'hC3, 8'h00);
        access(1'b0, REG_CFG, 8'h00, 8'hC3);
        $display("Test serial_spacing done");
        held = quad_phases;
        step(2'h3, 2'h1);
        check(quad_phases != held, 1'b1);
        access(1'b0, REG_DX, 8'h00, 8'h01);
        access(1'b0, REG_DY, 8'h00, 8'hFF);
        access(1'b0, REG_DX, 8'h00, 8'h00);
        $display("Test motion done");
        sleep_req = 1'b1;
        idle(11000);
        check(powered_down, 1'b1);
        held = quad_phases;
        step(2'h1, 2'h1);
        check(quad_phases, held);
        sleep_req = 1'b0;
        idle(6600);
        check(data_valid, 1'b1);
        check(quad_valid, 1'b0);
        check(motion_trusted, 1'b0);
        idle(2500);
        check(quad_valid, 1'b1);
        check(motion_trusted, 1'b1);
        check(quad_phases, held);
        access(1'b0, REG_DX, 8'h00, 8'h00);
        $display("Test sleep done");
        port_reset_req = 1'b1;
        idle(1);
        port_reset_req = 1'b0;
        idle(3000);
        check(powered_down, 1'b0);
        access(1'b0, REG_ID, 8'h00, ID_VALUE);
        $display("Test port_reset done");
        conclude();
    end
endmodule
